// File: verilog/pll_lock_ctl.sv
// Lock-change interrupt, source select interlocks, low-power and break
// handling for a clock-multiplying loop.
// Assumes clock levels and lock input synchronous to i_clk.
//
// Summary of operation
// [R01] In automatic mode, every lock toggle sets the interrupt flag.
// [R02] Interrupt request forwarded only when the interrupt enable is set.
// [R03] Flag sets on lock change whatever the enable bit says.
// [R04] Manual mode suppresses requests; flag reads 0.
// [R05] Software reads lock after an interrupt to learn its cause.
// [R06] Base source select may be set while lock reads 0.
// [R07] Software checks lock before selecting the divided VCO clock.
// [R08] Wait instruction changes nothing in this block.
// [R09] Before wait software may clear select and power-on bits.
// [R10] Stop instruction powers down the loop analog section.
// [R11] Before stop, software enables oscillator run and clears select.
// [R12] After stop, software powers loop, polls lock, then selects.
// [R13] Break clear enable set: break-time accesses clear the flag.
// [R14] A flag cleared in break stays cleared afterwards.
// [R15] Break clear enable clear: break-time accesses keep the flag.
// [R16] Reads or writes of loop control clear the flag; reset too.
// [R17] Power-off ignored while selected; select ignored while powered off.
// [R18] Source changeover waits three edges of each clock, output held.
// [R19] Manual mode makes lock read 0.
// [R20] Request is flag AND enable AND automatic mode, held until cleared.
//
// Our own choices: the plain strobed port and the register addresses.
`include "pll_ctl_map.svh"
`timescale 1ns/10ps
`default_nettype none
module pll_lock_ctl (
   input  wire logic                 i_clk,
   input  wire logic                 i_rst_n,
   input  wire pll_ctl_pkg::reg_req_t i_req,
   output logic [7:0]                o_rdata,
   input  wire logic                 i_lock,
   input  wire logic                 i_break,
   input  wire logic                 i_wait,
   input  wire logic                 i_stop,
   input  wire logic                 i_osc_level,
   input  wire logic                 i_vco_level,
   output logic                      o_irq,
   output logic                      o_loop_power_on,
   output logic                      o_auto_bandwidth,
   output logic                      o_track_mode,
   output logic                      o_base_source_select,
   output logic                      o_base_hold
);
   import pll_ctl_pkg::*;

   // ************************************************************
   // Reset release
   // ************************************************************
   logic rst_meta_r;
   logic rst_sync_r;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // ************************************************************
   // Register state
   // ************************************************************
   logic          irq_enable_r, irq_enable_nxt;
   logic          irq_flag_r, irq_flag_nxt;
   logic          power_on_r, power_on_nxt;
   logic          base_sel_r, base_sel_nxt;
   logic          auto_r, auto_nxt;
   logic          track_r, track_nxt;
   logic          clear_en_r, clear_en_nxt;
   logic          lock_prev_r, lock_prev_nxt;
   logic [7:0]    rdata_r, rdata_nxt;
   logic          lock_seen;
   logic          hit_ctl;
   logic          clear_ok;
   logic [7:0]    ctl_view;
   logic [7:0]    bw_view;

   assign hit_ctl   = (i_req.wr || i_req.rd) &&
                      i_req.addr == `LOOP_CONTROL_OFS;
   // Break protection gates only the side effect, never the access
   assign clear_ok  = hit_ctl && (!i_break || clear_en_r); // [R13] [R15]
   assign lock_seen = auto_r & i_lock;                    // [R19]

   always_comb begin
      ctl_view = 8'h00;
      ctl_view[`LC_IRQ_ENABLE_BIT] = irq_enable_r;
      ctl_view[`LC_IRQ_FLAG_BIT]   = irq_flag_r & auto_r;  // [R04]
      ctl_view[`LC_POWER_ON_BIT]   = power_on_r;
      ctl_view[`LC_BASE_SEL_BIT]   = base_sel_r;
      bw_view = 8'h00;
      bw_view[`BW_AUTO_BIT]  = auto_r;
      bw_view[`BW_LOCK_BIT]  = lock_seen;                 // [R19]
      bw_view[`BW_TRACK_BIT] = auto_r ? lock_seen : track_r;
   end

   always_comb begin
      irq_enable_nxt = irq_enable_r;
      power_on_nxt   = power_on_r;
      base_sel_nxt   = base_sel_r;
      auto_nxt       = auto_r;
      track_nxt      = track_r;
      clear_en_nxt   = clear_en_r;
      lock_prev_nxt  = lock_seen;
      rdata_nxt      = 8'h00;
      irq_flag_nxt   = irq_flag_r;
      // Clear from an access is applied first so a same-cycle
      // lock toggle still wins
      if (clear_ok) begin
         irq_flag_nxt = 1'b0;                             // [R16] [R14]
      end
      if (auto_r && (lock_seen != lock_prev_r)) begin
         irq_flag_nxt = 1'b1;                             // [R01] [R03]
      end
      if (i_req.wr) begin
         case (i_req.addr)
            `LOOP_CONTROL_OFS: begin
               irq_enable_nxt = i_req.wdata[`LC_IRQ_ENABLE_BIT];
               // Interlocks keep the VCO from driving while unpowered
               if (i_req.wdata[`LC_POWER_ON_BIT] || !base_sel_r) begin
                  power_on_nxt = i_req.wdata[`LC_POWER_ON_BIT]; // [R17]
               end
               // Lock status is deliberately not consulted here
               // Power must also stay on through this write, or one
               // write could leave the VCO selected and unpowered
               if (!i_req.wdata[`LC_BASE_SEL_BIT] ||
                   (power_on_r && i_req.wdata[`LC_POWER_ON_BIT])) begin
                  base_sel_nxt = i_req.wdata[`LC_BASE_SEL_BIT]; // [R17] [R06]
               end
            end
            `BANDWIDTH_CONTROL_OFS: begin
               auto_nxt = i_req.wdata[`BW_AUTO_BIT];
               if (!auto_r) begin
                  track_nxt = i_req.wdata[`BW_TRACK_BIT];
               end
            end
            `BREAK_FLAG_CTRL_OFS: begin
               clear_en_nxt = i_req.wdata[`BF_CLEAR_ENABLE_BIT];
            end
            default: begin
            end
         endcase
      end
      if (i_req.rd) begin
         case (i_req.addr)
            `LOOP_CONTROL_OFS:      rdata_nxt = ctl_view;
            `BANDWIDTH_CONTROL_OFS: rdata_nxt = bw_view;
            `BREAK_FLAG_CTRL_OFS: begin
               rdata_nxt = 8'h00;
               rdata_nxt[`BF_CLEAR_ENABLE_BIT] = clear_en_r;
            end
            default:                rdata_nxt = 8'h00;
         endcase
      end
   end

   // Wait input is deliberately unused: wait leaves all state alone
   always_ff @(posedge i_clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         irq_enable_r <= 1'(`LC_RESET_VAL >> `LC_IRQ_ENABLE_BIT);
         irq_flag_r   <= 1'b0;                            // [R16]
         power_on_r   <= 1'b1;
         base_sel_r   <= 1'b0;
         auto_r       <= 1'b0;
         track_r      <= 1'b0;
         clear_en_r   <= 1'b0;                            // [R15]
         lock_prev_r  <= 1'b0;
         rdata_r      <= 8'h00;
      end else begin
         irq_enable_r <= irq_enable_nxt;
         irq_flag_r   <= irq_flag_nxt;
         power_on_r   <= power_on_nxt;
         base_sel_r   <= base_sel_nxt;
         auto_r       <= auto_nxt;
         track_r      <= track_nxt;
         clear_en_r   <= clear_en_nxt;
         lock_prev_r  <= lock_prev_nxt;
         rdata_r      <= rdata_nxt;
      end
   end

   // ************************************************************
   // Base source changeover
   // ************************************************************
   switch_state_t sw_r, sw_nxt;
   logic          applied_r, applied_nxt;
   logic          osc_done, vco_done;
   logic          cnt_clear;

   assign cnt_clear = (sw_r == SW_IDLE);

   edge_count u_osc_cnt (
      .i_clk   (i_clk),
      .i_rst_n (rst_sync_r),
      .i_clear (cnt_clear),
      .i_level (i_osc_level),
      .o_done  (osc_done)
   );
   edge_count u_vco_cnt (
      .i_clk   (i_clk),
      .i_rst_n (rst_sync_r),
      .i_clear (cnt_clear),
      .i_level (i_vco_level),
      .o_done  (vco_done)
   );

   always_comb begin
      sw_nxt      = sw_r;
      applied_nxt = applied_r;
      case (sw_r)
         SW_IDLE: if (base_sel_r != applied_r) sw_nxt = SW_OLD;
         // Both clocks must tick three times before the mux flips
         SW_OLD:  if (osc_done && vco_done) sw_nxt = SW_NEW; // [R18]
         SW_NEW: begin
            applied_nxt = base_sel_r;
            sw_nxt      = SW_DONE;
         end
         SW_DONE: sw_nxt = SW_IDLE;
         default: sw_nxt = SW_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         sw_r      <= SW_IDLE;
         applied_r <= 1'b0;
      end else begin
         sw_r      <= sw_nxt;
         applied_r <= applied_nxt;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign o_rdata              = rdata_r;
   assign o_irq                = irq_flag_r & irq_enable_r & auto_r; // [R20] [R02] [R04]
   // Stop gates the analog section without touching the power bit
   assign o_loop_power_on      = power_on_r & ~i_stop;  // [R10] [R08]
   assign o_auto_bandwidth     = auto_r;
   assign o_track_mode         = auto_r ? lock_seen : track_r;
   assign o_base_source_select = applied_r;
   assign o_base_hold          = (sw_r != SW_IDLE);     // [R18]
endmodule : pll_lock_ctl
`default_nettype wire

// File: verilog/pll_ctl_map.svh
// Offsets, field positions, reset values and timing counts of the
// lock-interrupt and low-power control block.
// Assumes inclusion by bare name from design files.
`ifndef PLL_CTL_MAP_SVH
`define PLL_CTL_MAP_SVH
// ************************************************************
// Register offsets
// ************************************************************
`define LOOP_CONTROL_OFS      4'h0
`define BANDWIDTH_CONTROL_OFS 4'h1
`define BREAK_FLAG_CTRL_OFS   4'h2
// ************************************************************
// loop_control_reg fields
// ************************************************************
`define LC_IRQ_ENABLE_BIT     7
`define LC_IRQ_FLAG_BIT       6
`define LC_POWER_ON_BIT       5
`define LC_BASE_SEL_BIT       4
// ************************************************************
// bandwidth_control_reg fields
// ************************************************************
`define BW_AUTO_BIT           7
`define BW_LOCK_BIT           6
`define BW_TRACK_BIT          5
// ************************************************************
// break_flag_control_reg fields
// ************************************************************
`define BF_CLEAR_ENABLE_BIT   7
// ************************************************************
// Reset values and timing
// ************************************************************
`define LC_RESET_VAL          8'h20
`define BW_RESET_VAL          8'h00
`define BF_RESET_VAL          8'h00
`define SWITCH_SRC_CYCLES     3
`define SWITCH_CNT_W          2
`endif

// File: verilog/pll_ctl_pkg.sv
// Types shared by the lock-interrupt control block.
// Assumes nothing of its surroundings.
`default_nettype none
package pll_ctl_pkg;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } reg_req_t;
   typedef enum logic [3:0] {
      SW_IDLE = 4'b0001,
      SW_OLD  = 4'b0010,
      SW_NEW  = 4'b0100,
      SW_DONE = 4'b1000
   } switch_state_t;
endpackage : pll_ctl_pkg
`default_nettype wire

// File: verilog/edge_count.sv
// Counts edges of one source clock level, sampled on the bus clock.
// Assumes the level is already synchronous to i_clk.
`include "pll_ctl_map.svh"
`timescale 1ns/10ps
`default_nettype none
module edge_count (
   input  wire logic                     i_clk,
   input  wire logic                     i_rst_n,
   input  wire logic                     i_clear,
   input  wire logic                     i_level,
   output logic                          o_done
);
   logic                       prev_r;
   logic                       prev_nxt;
   logic [`SWITCH_CNT_W-1:0]   cnt_r;
   logic [`SWITCH_CNT_W-1:0]   cnt_nxt;

   always_comb begin
      prev_nxt = i_level;
      cnt_nxt  = cnt_r;
      if (i_clear) begin
         cnt_nxt = '0;
      end else if (i_level && !prev_r &&
                   cnt_r != `SWITCH_CNT_W'(`SWITCH_SRC_CYCLES)) begin
         cnt_nxt = cnt_r + 2'h1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prev_r <= 1'b0;
         cnt_r  <= '0;
      end else begin
         prev_r <= prev_nxt;
         cnt_r  <= cnt_nxt;
      end
   end

   assign o_done = (cnt_r == `SWITCH_CNT_W'(`SWITCH_SRC_CYCLES));
endmodule : edge_count
`default_nettype wire

// File: test/pll_lock_ctl_asserts.sv
// Port checker for the lock-interrupt control block.
// Assumes a bind onto pll_lock_ctl; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module pll_lock_ctl_asserts (
   input wire logic                  i_clk,
   input wire logic                  i_rst_n,
   input wire pll_ctl_pkg::reg_req_t i_req,
   input wire logic                  i_lock,
   input wire logic                  i_break,
   input wire logic                  i_stop,
   input wire logic                  o_irq,
   input wire logic                  o_loop_power_on,
   input wire logic                  o_auto_bandwidth,
   input wire logic                  o_base_source_select,
   input wire logic                  o_base_hold
);
   import pll_ctl_pkg::*;
   // ****
   // Shadow enables, since the checker cannot see the registers
   // ****
   logic       en_r;
   logic       bce_r;
   wire  logic acc0 = (i_req.wr || i_req.rd) && i_req.addr == 4'h0;
   wire  logic wr0  = i_req.wr && i_req.addr == 4'h0;
   wire  logic wr2  = i_req.wr && i_req.addr == 4'h2;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         en_r  <= 1'b0;
         bce_r <= 1'b0;
      end else begin
         en_r  <= wr0 ? i_req.wdata[7] : en_r;
         bce_r <= wr2 ? i_req.wdata[7] : bce_r;
      end
   end
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   sequence s_clr;
      acc0 && (!i_break || bce_r) && !$changed(i_lock);
   endsequence
   sequence s_sel_off;
      wr0 && i_req.wdata[4] && !o_loop_power_on && !i_stop;
   endsequence
   property p_set; $changed(i_lock) && o_auto_bandwidth && en_r
      |-> ##[1:2] o_irq; endproperty
   a_set: assert property (p_set)
      else $error("irq missing after lock change");
   property p_gate; o_irq |-> en_r && o_auto_bandwidth; endproperty
   a_gate: assert property (p_gate)
      else $error("irq without enable or auto");
   property p_hold; o_irq && !i_req.wr && !i_req.rd |=> o_irq; endproperty
   a_hold: assert property (p_hold)
      else $error("irq dropped without access");
   property p_clr; s_clr |=> !o_irq; endproperty
   a_clr: assert property (p_clr)
      else $error("access did not clear flag");
   property p_keep; acc0 && i_req.rd && i_break && !bce_r && o_irq
      |=> o_irq; endproperty
   a_keep: assert property (p_keep)
      else $error("flag cleared in protected break");
   property p_pwr; wr0 && !i_req.wdata[5] && o_base_source_select
      && !o_base_hold && !i_stop |=> o_loop_power_on; endproperty
   a_pwr: assert property (p_pwr)
      else $error("power dropped while selected");
   property p_nosel;
      (s_sel_off and (!o_base_hold && !o_base_source_select))
      |=> !o_base_hold [*4]; endproperty
   a_nosel: assert property (p_nosel)
      else $error("select taken while powered off");
   property p_chg; $changed(o_base_source_select) |-> o_base_hold;
   endproperty
   a_chg: assert property (p_chg)
      else $error("source changed without hold");
   property p_end; $rose(o_base_hold) |-> ##[1:100] !o_base_hold;
   endproperty
   a_end: assert property (p_end)
      else $error("changeover too long");
   property p_stop; i_stop |-> !o_loop_power_on; endproperty
   a_stop: assert property (p_stop)
      else $error("loop powered in stop");
endmodule : pll_lock_ctl_asserts
bind pll_lock_ctl pll_lock_ctl_asserts chk_u (.i_clk, .i_rst_n, .i_req,
   .i_lock, .i_break, .i_stop, .o_irq, .o_loop_power_on,
   .o_auto_bandwidth, .o_base_source_select, .o_base_hold);
`default_nettype wire

// File: test/pll_lock_ctl_tb.sv
// Self-checking bench for the lock-interrupt control block.
// Assumes the checker file is compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module pll_lock_ctl_tb;
   import pll_ctl_pkg::*;
   logic       i_clk = 0, i_rst_n = 0, lock = 0, brk = 0;
   logic       wt = 0, stp = 0, osc = 0, vco = 0;
   logic       irq, pwr, auto_bw, sel, hold, trk;
   logic [7:0] rdata;
   reg_req_t   req = '0;
   int         num_errors = 0, tests_run = 0, cyc = 0;
   pll_lock_ctl dut_u (.i_clk, .i_rst_n, .i_req(req), .o_rdata(rdata),
      .i_lock(lock), .i_break(brk), .i_wait(wt), .i_stop(stp),
      .i_osc_level(osc), .i_vco_level(vco), .o_irq(irq),
      .o_loop_power_on(pwr), .o_auto_bandwidth(auto_bw),
      .o_track_mode(trk), .o_base_source_select(sel), .o_base_hold(hold));
   // ****
   // Clock, source levels and hang guard
   // ****
   initial forever #2.5 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      osc <= ~osc;
      vco <= osc ? ~vco : vco;
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         num_errors++;
         summarize();
      end
   end
   task automatic summarize;
      if (num_errors == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize
   task automatic chk(input string n, input logic [7:0] s, e);
      tests_run++;
      if (s !== e) begin
         num_errors++;
         $display("mismatch %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask : tick
   // Strobes drop at the taking edge; the next call waits one edge first
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clk);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge i_clk);
      req <= '0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge i_clk);
      req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge i_clk);
      req <= '0;
      #1 chk($sformatf("reg%0h", a), rdata, e);
   endtask : rd
   task automatic sw(input logic e);
      int i = 0;
      // Look just after the edge so the outputs have settled
      while (hold !== 1'b1 && i < 20) begin
         @(posedge i_clk);
         #1;
         i++;
      end
      chk("hold", 8'(hold), 8'h01);
      while (hold !== 1'b0 && i < 150) begin
         @(posedge i_clk);
         #1;
         i++;
      end
      chk("hold", 8'(hold), 8'h00);
      chk("sel", 8'(sel), 8'(e));
   endtask : sw
   // ****
   // Scenarios
   // ****
   initial begin
      tick(5);
      i_rst_n <= 1'b1;
      tick(3);
      rd(4'h0, 8'h20);
      rd(4'h1, 8'h00);
      rd(4'h2, 8'h00);
      rd(4'h5, 8'h00);
      tick(1);
      lock <= 1'b1;
      tick(3);
      #1 chk("irq", 8'(irq), 8'h00);
      rd(4'h1, 8'h00);
      rd(4'h0, 8'h20);
      wr(4'h1, 8'h80);
      rd(4'h1, 8'he0);
      #1 chk("auto", 8'(auto_bw), 8'h01);
      tick(1);
      lock <= 1'b0;
      tick(3);
      #1 chk("irq", 8'(irq), 8'h00);
      rd(4'h0, 8'h60);
      rd(4'h0, 8'h20);
      wr(4'h0, 8'ha0);
      tick(1);
      lock <= 1'b1;
      tick(8);
      #1 chk("irq", 8'(irq), 8'h01);
      rd(4'h1, 8'he0);
      rd(4'h0, 8'he0);
      chk("irq", 8'(irq), 8'h00);
      tick(1);
      lock <= 1'b0;
      tick(3);
      brk <= 1'b1;
      wr(4'h0, 8'ha0);
      rd(4'h0, 8'he0);
      wr(4'h2, 8'h80);
      rd(4'h0, 8'he0);
      rd(4'h0, 8'ha0);
      tick(1);
      brk <= 1'b0;
      rd(4'h0, 8'ha0);
      wr(4'h2, 8'h00);
      tick(1);
      lock <= 1'b1;
      tick(3);
      wr(4'h1, 8'h00);
      #1 chk("irq", 8'(irq), 8'h00);
      rd(4'h0, 8'ha0);
      wr(4'h0, 8'h30);
      sw(1'b1);
      rd(4'h0, 8'h30);
      wr(4'h0, 8'h00);
      sw(1'b0);
      rd(4'h0, 8'h20);
      wr(4'h0, 8'h00);
      wr(4'h0, 8'h10);
      rd(4'h0, 8'h00);
      chk("hold", 8'(hold), 8'h00);
      wr(4'h0, 8'h20);
      tick(1);
      stp <= 1'b1;
      tick(1);
      #1 chk("pwr", 8'(pwr), 8'h00);
      tick(1);
      stp <= 1'b0;
      wt  <= 1'b1;
      tick(4);
      rd(4'h0, 8'h20);
      chk("pwr", 8'(pwr), 8'h01);
      wr(4'h1, 8'h80);
      rd(4'h1, 8'he0);
      #1 chk("trk", 8'(trk), 8'h01);
      wr(4'h0, 8'h30);
      sw(1'b1);
      wr(4'h0, 8'h20);
      sw(1'b0);
      wr(4'h0, 8'h00);
      stp <= 1'b1;
      tick(2);
      stp <= 1'b0;
      wr(4'h0, 8'h20);
      rd(4'h1, 8'he0);
      wr(4'h0, 8'h30);
      sw(1'b1);
      rd(4'h0, 8'h30);
      summarize();
   end
endmodule : pll_lock_ctl_tb
`default_nettype wire
